// *** rtl/tsd_map.svh ***
/*
  Field positions, reserved masks and counts for the triangle setup state
  packet decoder. Assumes inclusion by bare name from the streamer and setup modules.
*/
`ifndef TSD_MAP_SVH
`define TSD_MAP_SVH

// ==========================================================
// Header word
`define TSD_LEN_HI 7
`define TSD_LEN_LO 0
`define TSD_LEN_DEFAULT 8'h12
`define TSD_LEN_BIAS 8'h02
`define TSD_PKT_WORDS 5'h14
`define TSD_OP_HI 31
`define TSD_OP_LO 16
`define TSD_OPCODE 16'h7813

// ==========================================================
// First payload word
`define TSD_W1_RD_OFF_HI 9
`define TSD_W1_RD_OFF_LO 4
`define TSD_W1_RSVD_MASK 32'h0000040f

// ==========================================================
// Second payload word
`define TSD_W2_RSVD_MASK 32'hfffff004
`define TSD_W2_LEGACY_BIAS 11
`define TSD_W2_STATS_EN 10
`define TSD_W2_DOFS_SOLID 9
`define TSD_W2_DOFS_WIRE 8
`define TSD_W2_DOFS_POINT 7
`define TSD_W2_FRONT_HI 6
`define TSD_W2_FRONT_LO 5
`define TSD_W2_BACK_HI 4
`define TSD_W2_BACK_LO 3
`define TSD_W2_VP_EN 1
`define TSD_W2_WINDING 0

// ==========================================================
// Payload word indices within the packet
`define TSD_IDX_W1 5'h01
`define TSD_IDX_W2 5'h02

`endif

// *** rtl/tsd_pkg.sv ***
/*
  Types for the triangle setup state packet decoder.
  Assumes tsd_map.svh is on the include path.
*/
package tsd_pkg;
  typedef enum logic [1:0] {
    TSD_FILL_SOLID = 2'h0,
    TSD_FILL_WIRE = 2'h1,
    TSD_FILL_POINT = 2'h2,
    TSD_FILL_RSVD = 2'h3
  } tsd_fill_e;

  typedef logic [31:0] tsd_word_t;

  typedef struct packed {
    logic [5:0] read_offset;
    logic legacy_bias;
    logic stats_en;
    logic dofs_solid;
    logic dofs_wire;
    logic dofs_point;
    tsd_fill_e front_fill;
    tsd_fill_e back_fill;
    logic vp_en;
    logic front_ccw;
  } tsd_state_s;
endpackage : tsd_pkg

// *** rtl/tsd_link_if.sv ***
/*
  Word stream from command streamer to triangle setup decoder.
  Assumes both ends share i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsd_link_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  logic last;
  modport streamer (output valid, output data, output last, input ready);
  modport setup (input valid, input data, input last, output ready);
endinterface : tsd_link_if
`default_nettype wire

// *** rtl/tsd_streamer.sv ***
/*
  Command streamer end: builds a setup state packet from user fields
  and sends it word by word. Assumes the setup end on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsd_map.svh"
module tsd_streamer
  import tsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_send,
  input var tsd_state_s i_state,
  input wire logic i_rect_list,
  output logic o_busy,
  tsd_link_if.streamer link
);
  logic [4:0] idx;
  tsd_state_s held;
  tsd_word_t w1;
  tsd_word_t w2;
  tsd_fill_e ff;
  tsd_fill_e bf;

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
      idx <= 5'h00;
      held <= '0;
    end else if (!o_busy) begin
      if (i_send) begin
        o_busy <= 1'b1;
        idx <= 5'h00;
        held <= i_state;
        // Rectangles must go solid on both faces
        if (i_rect_list) begin
          held.front_fill <= TSD_FILL_SOLID;
          held.back_fill <= TSD_FILL_SOLID;
        end
      end
    end else if (link.ready) begin
      if (idx == `TSD_PKT_WORDS - 5'h01) begin
        o_busy <= 1'b0;
      end
      idx <= idx + 5'h01;
    end
  end

  // ==========================================================
  // Word assembly; reserved bits stay zero
  always_comb begin
    // Reserved encoding is never sent
    ff = (held.front_fill == TSD_FILL_RSVD) ? TSD_FILL_SOLID : held.front_fill;
    bf = (held.back_fill == TSD_FILL_RSVD) ? TSD_FILL_SOLID : held.back_fill;
    w1 = '0;
    w1[`TSD_W1_RD_OFF_HI:`TSD_W1_RD_OFF_LO] = held.read_offset;
    w2 = '0;
    w2[`TSD_W2_LEGACY_BIAS] = held.legacy_bias;
    // Caller supplies clip-enabled and clip stats combined
    w2[`TSD_W2_STATS_EN] = held.stats_en;
    w2[`TSD_W2_DOFS_SOLID] = held.dofs_solid;
    w2[`TSD_W2_DOFS_WIRE] = held.dofs_wire;
    w2[`TSD_W2_DOFS_POINT] = held.dofs_point;
    w2[`TSD_W2_FRONT_HI:`TSD_W2_FRONT_LO] = ff;
    w2[`TSD_W2_BACK_HI:`TSD_W2_BACK_LO] = bf;
    w2[`TSD_W2_VP_EN] = held.vp_en;
    w2[`TSD_W2_WINDING] = held.front_ccw;
  end

  // ==========================================================
  // Link drive
  always_comb begin
    link.valid = o_busy;
    link.last = o_busy && (idx == `TSD_PKT_WORDS - 5'h01);
    link.data = '0;
    if (idx == 5'h00) begin
      link.data[`TSD_OP_HI:`TSD_OP_LO] = `TSD_OPCODE;
      link.data[`TSD_LEN_HI:`TSD_LEN_LO] = `TSD_LEN_DEFAULT;
    end else if (idx == `TSD_IDX_W1) begin
      link.data = w1;
    end else if (idx == `TSD_IDX_W2) begin
      link.data = w2;
    end
  end
endmodule : tsd_streamer
`default_nettype wire

// *** rtl/tsd_setup.sv ***
/*
  Triangle setup stage end: takes the setup state packet, checks its
  length, latches decoded controls on the last word and drives them to
  raster and depth logic, plus per-primitive facing and fill choice.
  Assumes the streamer on the same clock and a per-primitive strobe.
  Limitation: a reserved fill code 3 from the writer still reaches the
  primitive fill output, with depth offset forced off for it.
  Statistics count every valid primitive while the stats bit is on;
  the clip-stage gating is left to the packet writer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsd_map.svh"
// Contract
// - Word1 bits 9:4 give vertex read offset
// - Writer zeroes all reserved payload bits
// - Bit 11 picks raw or scaled constant
// - Bit 10 enables clip primitive counting
// - Stats bit only when clip stats on
// - Bit 9 enables depth offset, solid
// - Bit 8 enables depth offset, wireframe
// - Bit 7 enables depth offset, point
// - Bits 6:5 front fill, 3 reserved
// - Bits 4:3 back fill, 3 reserved
// - Wireframe draws visible edges as lines
// - Point mode only at original visible vertices
// - Rectangle lists require solid both faces
// - Bit 1 gates viewport transform
// - Bit 0 selects clockwise or counterclockwise front
// - Length field equals total words minus two
// - Facing drives culling and fill choice
module tsd_setup
  import tsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_prim_valid,
  input wire logic i_prim_is_tri,
  input wire logic i_prim_cw,
  input wire logic i_prim_clipped_vtx,
  input wire logic [2:0] i_edge_vis,
  output logic [5:0] o_read_offset,
  output logic o_legacy_bias,
  output logic o_vp_en,
  output logic o_front_ccw,
  output tsd_fill_e o_front_fill,
  output tsd_fill_e o_back_fill,
  output logic o_prim_valid,
  output logic o_prim_front,
  output tsd_fill_e o_prim_fill,
  output logic o_prim_dofs_en,
  output logic [2:0] o_prim_edge_en,
  output logic [2:0] o_prim_point_en,
  output logic [31:0] o_clip_primitive_counter,
  output logic o_len_err,
  tsd_link_if.setup link
);
  // Position of the next word within the packet
  logic [4:0] idx;
  logic [7:0] len_field;
  tsd_word_t w1;
  tsd_word_t w2;
  tsd_state_s cur;
  logic take;
  logic pkt_end;
  logic len_ok;
  logic next_front;
  tsd_fill_e next_fill;
  logic next_dofs;

  assign take = link.valid && link.ready;
  assign pkt_end = take && link.last;
  // Count includes the final word, taken in this same cycle
  assign len_ok = ({3'h0, idx + 5'h01} == len_field + `TSD_LEN_BIAS);

  // ==========================================================
  // Link acceptance
  // Accepts every cycle once out of reset (ready low in reset); the decode needs no stall
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      link.ready <= 1'b0;
    end else begin
      link.ready <= 1'b1;
    end
  end

  // ==========================================================
  // Word capture
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      idx <= 5'h00;
      len_field <= 8'h00;
      w1 <= '0;
      w2 <= '0;
    end else if (take) begin
      idx <= link.last ? 5'h00 : idx + 5'h01;
      if (idx == 5'h00) begin
        // Kept for the end-of-packet length check
        len_field <= link.data[`TSD_LEN_HI:`TSD_LEN_LO];
      end
      if (idx == `TSD_IDX_W1) begin
        w1 <= link.data;
      end
      if (idx == `TSD_IDX_W2) begin
        w2 <= link.data;
      end
    end
  end

  // ==========================================================
  // Latch on last word; a bad length leaves old state in place
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_len_err <= 1'b0;
    end else if (pkt_end) begin
      o_len_err <= !len_ok;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else if (pkt_end && len_ok) begin
      cur.read_offset <= w1[`TSD_W1_RD_OFF_HI:`TSD_W1_RD_OFF_LO];
      cur.legacy_bias <= w2[`TSD_W2_LEGACY_BIAS];
      cur.stats_en <= w2[`TSD_W2_STATS_EN];
      cur.dofs_solid <= w2[`TSD_W2_DOFS_SOLID];
      cur.dofs_wire <= w2[`TSD_W2_DOFS_WIRE];
      cur.dofs_point <= w2[`TSD_W2_DOFS_POINT];
      cur.front_fill <= tsd_fill_e'(w2[`TSD_W2_FRONT_HI:`TSD_W2_FRONT_LO]);
      cur.back_fill <= tsd_fill_e'(w2[`TSD_W2_BACK_HI:`TSD_W2_BACK_LO]);
      cur.vp_en <= w2[`TSD_W2_VP_EN];
      cur.front_ccw <= w2[`TSD_W2_WINDING];
    end
  end

  // ==========================================================
  // Controls seen by raster and depth logic, each from its own flop
  // so that downstream timing never sees the decode path
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_read_offset <= 6'h00;
      o_legacy_bias <= 1'b0;
      o_vp_en <= 1'b0;
      o_front_ccw <= 1'b0;
      o_front_fill <= TSD_FILL_SOLID;
      o_back_fill <= TSD_FILL_SOLID;
    end else if (pkt_end && len_ok) begin
      o_read_offset <= w1[`TSD_W1_RD_OFF_HI:`TSD_W1_RD_OFF_LO];
      o_legacy_bias <= w2[`TSD_W2_LEGACY_BIAS];
      o_vp_en <= w2[`TSD_W2_VP_EN];
      o_front_ccw <= w2[`TSD_W2_WINDING];
      o_front_fill <= tsd_fill_e'(w2[`TSD_W2_FRONT_HI:`TSD_W2_FRONT_LO]);
      o_back_fill <= tsd_fill_e'(w2[`TSD_W2_BACK_HI:`TSD_W2_BACK_LO]);
    end
  end

  // ==========================================================
  // Per-primitive facing and fill
  always_comb begin
    // Points and lines always count as front facing
    next_front = !i_prim_is_tri || (i_prim_cw != cur.front_ccw);
    next_fill = next_front ? cur.front_fill : cur.back_fill;
    if (!i_prim_is_tri) begin
      next_fill = TSD_FILL_SOLID;
    end
    unique case (next_fill)
      TSD_FILL_SOLID: next_dofs = cur.dofs_solid;
      TSD_FILL_WIRE: next_dofs = cur.dofs_wire;
      TSD_FILL_POINT: next_dofs = cur.dofs_point;
      default: next_dofs = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prim_valid <= 1'b0;
      o_prim_front <= 1'b0;
      o_prim_fill <= TSD_FILL_SOLID;
      o_prim_dofs_en <= 1'b0;
      o_prim_edge_en <= 3'h0;
      o_prim_point_en <= 3'h0;
    end else begin
      // One-cycle pulse, one cycle behind the primitive strobe
      o_prim_valid <= i_prim_valid;
      o_prim_front <= next_front;
      o_prim_fill <= next_fill;
      o_prim_dofs_en <= next_dofs;
      // Edges masked by per-edge visibility flags
      o_prim_edge_en <= (next_fill == TSD_FILL_WIRE) ? i_edge_vis : 3'h0;
      // Clip-inserted vertices never get points
      o_prim_point_en <= (next_fill == TSD_FILL_POINT && !i_prim_clipped_vtx) ? i_edge_vis : 3'h0;
    end
  end

  // ==========================================================
  // Statistics on behalf of the clip stage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_clip_primitive_counter <= 32'h0000_0000;
    // Wraps at 32 bits; readers are expected to take differences
    end else if (i_prim_valid && cur.stats_en) begin
      o_clip_primitive_counter <= o_clip_primitive_counter + 32'h0000_0001;
    end
  end
endmodule : tsd_setup
`default_nettype wire

// *** test/tsd_link_asserts.sv ***
/* Checker on the packet word stream between the two ends.
   Assumes tb instantiates it beside the link, on one clock. */
`timescale 1ns/1ps
`default_nettype none
module tsd_link_asserts (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic valid,
  input wire logic ready,
  input wire logic [31:0] data,
  input wire logic last
);
  logic [4:0] cnt;
  // ====
  // Word position, so each check knows which word is on the wire
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || (valid && ready && last)) begin
      cnt <= 5'h00;
    end else if (valid && ready) begin
      cnt <= cnt + 5'h01;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ====
  // Properties
  property p_hdr; valid && cnt == 5'h00 |-> data[31:16] == 16'h7813 && data[7:0] == 8'h12; endproperty
  property p_w1; valid && cnt == 5'h01 |-> (data & 32'h0000040f) == 32'h0; endproperty
  property p_w2; valid && cnt == 5'h02 |-> (data & 32'hfffff004) == 32'h0; endproperty
  property p_fill; valid && cnt == 5'h02 |-> data[6:5] != 2'h3 && data[4:3] != 2'h3; endproperty
  property p_last; valid && ready && last |-> cnt == 5'h13; endproperty
  property p_pad; valid && cnt > 5'h02 |-> data == 32'h0; endproperty
  property p_hold; valid && !ready |=> valid && $stable(data) && $stable(last); endproperty
  property p_gap; valid && ready && last |=> !valid; endproperty
  a_hdr: assert property (p_hdr)
    else $error("bad header word");
  a_w1: assert property (p_w1)
    else $error("reserved bits set in word 1");
  a_w2: assert property (p_w2)
    else $error("reserved bits set in word 2");
  a_fill: assert property (p_fill)
    else $error("reserved fill code sent");
  a_last: assert property (p_last)
    else $error("packet length wrong");
  a_pad: assert property (p_pad)
    else $error("pad word not zero");
  a_hold: assert property (p_hold)
    else $error("word changed while stalled");
  a_gap: assert property (p_gap)
    else $error("no idle cycle after packet");
  c_pkt: cover property (valid && ready && last);
  c_w2: cover property (valid && cnt == 5'h02 && data[6:5] == 2'h2);
  c_stall: cover property (valid && !ready);
endmodule : tsd_link_asserts
`default_nettype wire

// *** test/tb.sv ***
/* Testbench: both ends joined by the link, user sides driven here.
   Assumes rtl/ on the include path. */
`timescale 1ns/1ps
`default_nettype none
module tb
  import tsd_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_send = 1'b0;
  logic i_rect_list = 1'b0;
  logic i_prim_valid = 1'b0;
  logic i_prim_cw = 1'b0;
  logic i_prim_is_tri = 1'b1;
  logic i_prim_clipped_vtx = 1'b0;
  logic [2:0] i_edge_vis = 3'h5;
  tsd_state_s i_state = '0;
  tsd_state_s cur;
  logic o_busy, o_legacy_bias, o_vp_en, o_front_ccw, o_prim_valid, o_prim_front, o_prim_dofs_en, o_len_err;
  logic [5:0] o_read_offset;
  logic [2:0] o_prim_edge_en, o_prim_point_en;
  logic [31:0] o_clip_primitive_counter;
  tsd_fill_e o_front_fill, o_back_fill, o_prim_fill;
  int errors = 0;
  int cmp_count = 0;
  always #20 i_clk = ~i_clk;
  tsd_link_if tsd_link_if_inst ();
  tsd_streamer tsd_streamer_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_send(i_send), .i_state(i_state),
    .i_rect_list(i_rect_list), .o_busy(o_busy), .link(tsd_link_if_inst));
  tsd_setup tsd_setup_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_prim_valid(i_prim_valid),
    .i_prim_is_tri(i_prim_is_tri), .i_prim_cw(i_prim_cw), .i_prim_clipped_vtx(i_prim_clipped_vtx),
    .i_edge_vis(i_edge_vis),
    .o_read_offset(o_read_offset), .o_legacy_bias(o_legacy_bias), .o_vp_en(o_vp_en), .o_front_ccw(o_front_ccw),
    .o_front_fill(o_front_fill), .o_back_fill(o_back_fill), .o_prim_valid(o_prim_valid),
    .o_prim_front(o_prim_front), .o_prim_fill(o_prim_fill), .o_prim_dofs_en(o_prim_dofs_en),
    .o_prim_edge_en(o_prim_edge_en), .o_prim_point_en(o_prim_point_en),
    .o_clip_primitive_counter(o_clip_primitive_counter), .o_len_err(o_len_err), .link(tsd_link_if_inst));
  tsd_link_asserts tsd_link_asserts_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .valid(tsd_link_if_inst.valid),
    .ready(tsd_link_if_inst.ready), .data(tsd_link_if_inst.data), .last(tsd_link_if_inst.last));
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ====
  // Scenarios
  task automatic t_packet(input tsd_state_s s, input logic rect);
    int n;
    @(posedge i_clk);
    i_state <= s;
    i_rect_list <= rect;
    i_send <= 1'b1;
    @(posedge i_clk);
    i_send <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      #1;
      if (!o_busy) break;
    end
    if (n == 40) begin
      errors++;
      final_report();
    end
    @(posedge i_clk);
    #1;
    cur = s;
    if (rect) cur.front_fill = TSD_FILL_SOLID;
    if (rect) cur.back_fill = TSD_FILL_SOLID;
    chk(o_read_offset, s.read_offset);
    chk(o_legacy_bias, s.legacy_bias);
    chk(o_vp_en, s.vp_en);
    chk(o_front_ccw, s.front_ccw);
    chk(o_front_fill, cur.front_fill);
    chk(o_back_fill, cur.back_fill);
    chk(o_len_err, 1'b0);
  endtask : t_packet
  task automatic t_prim(input logic cw, input logic is_tri, input logic clip);
    logic [31:0] c0;
    logic fr;
    tsd_fill_e f;
    c0 = o_clip_primitive_counter;
    // Points and lines are always front facing and solid
    fr = !is_tri || (cw ^ cur.front_ccw);
    f = !is_tri ? TSD_FILL_SOLID : fr ? cur.front_fill : cur.back_fill;
    @(posedge i_clk);
    i_prim_cw <= cw;
    i_prim_is_tri <= is_tri;
    i_prim_clipped_vtx <= clip;
    i_prim_valid <= 1'b1;
    @(posedge i_clk);
    i_prim_valid <= 1'b0;
    #1;
    chk(o_prim_valid, 1'b1);
    chk(o_prim_front, fr);
    chk(o_prim_fill, f);
    chk(o_prim_dofs_en, f == TSD_FILL_SOLID ? cur.dofs_solid : f == TSD_FILL_WIRE ? cur.dofs_wire : cur.dofs_point);
    chk(o_prim_edge_en, f == TSD_FILL_WIRE ? i_edge_vis : 3'h0);
    chk(o_prim_point_en, (f == TSD_FILL_POINT && !clip) ? i_edge_vis : 3'h0);
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_clip_primitive_counter, c0 + (cur.stats_en ? 32'h1 : 32'h0));
  endtask : t_prim
  initial begin
    tsd_state_s s;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    s = '{6'h3f, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, TSD_FILL_SOLID, TSD_FILL_SOLID, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      s.front_fill = tsd_fill_e'(i);
      s.back_fill = tsd_fill_e'(2 - i);
      s.read_offset = 6'h3f >> (i * 3);
      s.front_ccw = i[0];
      s.dofs_wire = i[1];
      t_packet(s, 1'b0);
      t_prim(1'b1, 1'b1, 1'b0);
      t_prim(1'b0, 1'b1, 1'b0);
    end
    t_prim(1'b1, 1'b1, 1'b1);
    t_prim(1'b0, 1'b0, 1'b0);
    s.stats_en = 1'b0;
    s.legacy_bias = 1'b0;
    s.vp_en = 1'b0;
    s.front_fill = TSD_FILL_WIRE;
    t_packet(s, 1'b1);
    t_prim(1'b1, 1'b1, 1'b0);
    final_report();
  end
endmodule : tb
`default_nettype wire
